// [logic/cfl_defines.svh]
// Constants for the configuration loader: timing counts, commands and field sizes.
`ifndef CFL_DEFINES_SVH
`define CFL_DEFINES_SVH
`define CFL_CLK_MHZ 40
`define CFL_RST_LOW_NS 1000
`define CFL_RST_LOW_CYC ((`CFL_RST_LOW_NS*`CFL_CLK_MHZ+999)/1000)
`define CFL_WAKE_GAP_US 30
`define CFL_WAKE_GAP_CYC (`CFL_WAKE_GAP_US*`CFL_CLK_MHZ)
`define CFL_SCK_HALF 4
`define CFL_SAMPLE_AT 2
`define CFL_CMD_WAKE 8'hab
`define CFL_CMD_FREAD 8'h0b
`define CFL_START_ADDR 24'h000000
`define CFL_CMD_BITS 8
`define CFL_DUMMY_BITS 8
`define CFL_WORD_BITS 32
`endif

// [logic/cfl_pkg.sv]
// Types shared by the configuration loader.
package cfl_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_WAKE = 3'b001, ST_GAP = 3'b010, ST_READ = 3'b011,
		ST_STREAM = 3'b100, ST_PASSIVE = 3'b101, ST_JTAG = 3'b110, ST_DONE = 3'b111
	} cfl_state_e;
	typedef enum logic [1:0] {
		MODE_ACTIVE = 2'b00, MODE_PASSIVE = 2'b01, MODE_JTAG = 2'b10, MODE_NONE = 2'b11
	} cfl_mode_e;
	typedef enum logic [1:0] {
		AW_X1 = 2'b00, AW_X2 = 2'b01, AW_X4 = 2'b10, AW_RSV = 2'b11
	} cfl_awidth_e;
	typedef struct packed {
		cfl_state_e state;
		logic rs1, rs2, rs3;
		logic [15:0] lowcnt;
		cfl_mode_e m1, m2, mode;
		cfl_awidth_e a1, a2, aw;
		logic r1, r2, mimg;
		logic [3:0] io1, io2;
		logic t1, t2, t3, d1, d2, s1, s2;
		logic sck, cs_n;
		logic [2:0] div;
		logic [15:0] timer;
		logic [5:0] cnt;
		logic [31:0] sh;
		logic [5:0] bits;
		logic pend;
		logic [31:0] word;
		logic [19:0] addr;
	} cfl_main_s;
	typedef struct packed {
		logic [2:0] w1, w2;
		logic [31:0] acc;
		logic [5:0] cnt;
		logic pvalid;
		logic [31:0] pdata;
	} cfl_link_s;
endpackage

// [logic/cfl_loader.sv]
// Configuration loader: active flash reader, passive slave, JTAG shifter and crossing FIFO.
`timescale 1ns/1ps
`include "cfl_defines.svh"

// Dual-clock FIFO with gray-coded pointers; DEPTH must be a power of two, at least 4.
module cfl_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 4
) (
	// Clocks and reset.
	input logic wclk,
	input logic rclk,
	input logic rst_n,
	// Filling side.
	input logic wr_valid,
	output logic wr_ready,
	input logic [W-1:0] wr_data,
	// Draining side.
	output logic rd_valid,
	input logic rd_ready,
	output logic [W-1:0] rd_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] bin, gry, s1, s2;
	} cfl_ptr_s;
	cfl_ptr_s ws, wn, rs, rn; // Pointer and synchroniser state of each side.
	logic [W-1:0] mem [DEPTH]; // Storage words.
	logic full, empty;

	// Binary to gray conversion, used by both pointers.
	function automatic logic [AW:0] to_gray(logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	// Full compares against the far pointer with its two top bits inverted.
	assign full = ws.gry == {~ws.s2[AW:AW-1], ws.s2[AW-2:0]};
	assign empty = rs.gry == rs.s2;
	assign wr_ready = !full;
	assign rd_valid = !empty;
	assign rd_data = mem[rs.bin[AW-1:0]];

	// Write side next state; the read pointer arrives through two flops.
	always_comb begin
		wn = ws;
		wn.s1 = rs.gry;
		wn.s2 = ws.s1;
		if (wr_valid && !full) begin
			wn.bin = ws.bin + 1'b1;
			wn.gry = to_gray(wn.bin);
		end
	end

	// Read side next state.
	always_comb begin
		rn = rs;
		rn.s1 = ws.gry;
		rn.s2 = rs.s1;
		if (rd_ready && !empty) begin
			rn.bin = rs.bin + 1'b1;
			rn.gry = to_gray(rn.bin);
		end
	end

	// Write clock registers.
	always_ff @(posedge wclk or negedge rst_n) begin
		if (!rst_n) begin
			ws <= '0;
		end else begin
			ws <= wn;
		end
	end

	// Storage has no reset; a word is only read after its pointer has crossed.
	always_ff @(posedge wclk) begin
		if (wr_valid && !full) begin
			mem[ws.bin[AW-1:0]] <= wr_data;
		end
	end

	// Read clock registers.
	always_ff @(posedge rclk or negedge rst_n) begin
		if (!rst_n) begin
			rs <= '0;
		end else begin
			rs <= rn;
		end
	end
endmodule

// What this block does
// - Load configuration memory, then enter user mode.
// - Held-low reset rising edge starts loading.
// - Active mode makes flash clock internally.
// - Send power-down release before any read.
// - Wait at least 30 us before fast read.
// - Fast read from address zero onward.
// - Active, passive x1..x32, and JTAG modes.
// - JTAG mode shifts bitstream one bit wide.
// - Active x1/x2/x4; multi-image not at x1.
module cfl_loader #(
	parameter logic [19:0] BITSTREAM_WORDS = 20'd1024,
	parameter int FIFO_DEPTH = 4
) (
	// System clock and reset.
	input logic mclk,
	input logic rst_n,
	// Configuration pins and straps.
	input logic config_reset_n,
	input cfl_pkg::cfl_mode_e cfg_mode,
	input cfl_pkg::cfl_awidth_e act_width,
	input logic [2:0] pas_width,
	input logic multi_image_req,
	// Status.
	output logic user_mode,
	output logic cfg_busy,
	output logic multi_image_ok,
	// Active mode flash pins.
	output logic spi_sck,
	output logic spi_cs_n,
	output logic [3:0] spi_io_o,
	output logic [3:0] spi_io_oe_n,
	input logic [3:0] spi_io_i,
	// Passive mode link, on the master's clock.
	input logic pas_clk,
	input logic pas_cs_n,
	input logic [31:0] pas_data,
	output logic pas_ready,
	// JTAG configuration path.
	input logic jtag_tck,
	input logic jtag_tdi,
	input logic jtag_shift,
	// Configuration memory write port.
	output logic config_memory_we,
	output logic [19:0] config_memory_addr,
	output logic [31:0] config_memory_wdata,
	input logic config_memory_ready
);
	import cfl_pkg::*;

	localparam logic [15:0] LOWC = 16'(`CFL_RST_LOW_CYC);
	localparam logic [15:0] GAPC = 16'(`CFL_WAKE_GAP_CYC);
	localparam logic [5:0] WB = 6'(`CFL_WORD_BITS);
	localparam int GAPI = `CFL_WAKE_GAP_CYC;

	cfl_main_s st, n; // System clock state and its next value.
	cfl_link_s lk, ln; // Passive link state and its next value.
	logic f_wready, f_rvalid, f_rready; // FIFO handshakes.
	logic [31:0] f_rdata; // FIFO head word.
	logic run, tick, samp, start; // Divider and sequencing strobes.
	logic [5:0] nb; // Passive beat width in bits.
	logic [31:0] beat; // Passive beat merged into the partial word.

	// Bits that one active sample adds.
	function automatic logic [5:0] act_w(cfl_awidth_e a);
		case (a)
			AW_X2: return 6'd2;
			AW_X4: return 6'd4;
			default: return 6'd1;
		endcase
	endfunction

	// Shift one active sample into the word; x1 reads the flash data-out line.
	function automatic logic [31:0] act_take(cfl_awidth_e a, logic [31:0] s, logic [3:0] io);
		case (a)
			AW_X2: return {s[29:0], io[1:0]};
			AW_X4: return {s[27:0], io};
			default: return {s[30:0], io[1]};
		endcase
	endfunction

	// Passive width code 0..5 means x1..x32.
	function automatic logic [5:0] pas_bits(logic [2:0] c);
		return (c > 3'd5) ? 6'd32 : (6'd1 << c);
	endfunction

	// The passive data crosses into the system clock through the FIFO.
	cfl_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
		.wclk(pas_clk),
		.rclk(mclk),
		.rst_n(rst_n),
		.wr_valid(lk.pvalid),
		.wr_ready(f_wready),
		.wr_data(lk.pdata),
		.rd_valid(f_rvalid),
		.rd_ready(f_rready),
		.rd_data(f_rdata)
	);

	// Passive link: the master clocks beats in only while pas_ready is high.
	always_comb begin
		ln = lk;
		ln.w1 = pas_width;
		ln.w2 = lk.w1;
		nb = pas_bits(lk.w2);
		beat = (lk.acc << nb) | (pas_data & ~(32'hffffffff << nb));
		if (lk.pvalid && f_wready) begin
			ln.pvalid = 1'b0;
		end
		if (!pas_cs_n && !lk.pvalid) begin
			if (lk.cnt + nb == WB) begin
				ln.pdata = beat;
				ln.pvalid = 1'b1;
				ln.cnt = 6'd0;
				ln.acc = '0;
			end else begin
				ln.acc = beat;
				ln.cnt = lk.cnt + nb;
			end
		end
	end

	// A held word stalls the master; FIFO back-pressure reaches it this way.
	assign pas_ready = !lk.pvalid;

	// Link clock registers.
	always_ff @(posedge pas_clk or negedge rst_n) begin
		if (!rst_n) begin
			lk <= '0;
		end else begin
			lk <= ln;
		end
	end

	// Sequencer next state for all three modes.
	always_comb begin
		n = st;
		n.rs1 = config_reset_n;
		n.rs2 = st.rs1;
		n.rs3 = st.rs2;
		n.m1 = cfg_mode;
		n.m2 = st.m1;
		n.a1 = act_width;
		n.a2 = st.a1;
		n.r1 = multi_image_req;
		n.r2 = st.r1;
		n.io1 = spi_io_i;
		n.io2 = st.io1;
		n.t1 = jtag_tck;
		n.t2 = st.t1;
		n.t3 = st.t2;
		n.d1 = jtag_tdi;
		n.d2 = st.d1;
		n.s1 = jtag_shift;
		n.s2 = st.s1;
		// Measure how long the reset pin has been low, saturating.
		if (!st.rs2) begin
			n.lowcnt = (st.lowcnt == LOWC) ? st.lowcnt : st.lowcnt + 16'd1;
		end else begin
			n.lowcnt = 16'd0;
		end
		start = st.rs2 && !st.rs3 && st.lowcnt == LOWC;
		// The clock stops while the shift word is full: one cycle for the hand-off, longer if the output buffer is also full.
		run = (st.state == ST_WAKE || st.state == ST_READ || st.state == ST_STREAM)
			&& st.bits != WB;
		tick = 1'b0;
		if (run) begin
			n.div = st.div + 3'd1;
			if (st.div == 3'(`CFL_SCK_HALF - 1)) begin
				n.div = 3'd0;
				tick = 1'b1;
			end
		end
		// Sample late in the high phase so the two-flop delay still sees stable data.
		samp = run && st.sck && st.state == ST_STREAM && st.div == 3'(`CFL_SAMPLE_AT);
		// Memory write; the final accepted word ends configuration.
		if (st.pend && config_memory_ready) begin
			n.pend = 1'b0;
			n.addr = st.addr + 20'd1;
			if (st.addr == BITSTREAM_WORDS - 20'd1) begin
				n.state = ST_DONE;
				n.cs_n = 1'b1;
				n.sck = 1'b0;
			end
		end
		// Hand a full shift word to the output buffer.
		// Only the shifting states own the shift word, so a word left over at done is dropped.
		if (st.bits == WB && !st.pend && (st.state == ST_STREAM || st.state == ST_JTAG)) begin
			n.word = st.sh;
			n.pend = 1'b1;
			n.bits = 6'd0;
		end
		case (st.state)
			ST_IDLE: begin
				if (start) begin
					n.mode = st.m2;
					n.aw = st.a2;
					n.mimg = st.r2 && st.a2 != AW_X1;
					n.addr = 20'd0;
					n.bits = 6'd0;
					case (st.m2)
						MODE_ACTIVE: begin
							n.state = ST_WAKE;
							n.cs_n = 1'b0;
							n.sh = {`CFL_CMD_WAKE, 24'h000000};
							n.cnt = 6'(`CFL_CMD_BITS);
							n.div = 3'd0;
						end
						MODE_PASSIVE: begin
							n.state = ST_PASSIVE;
						end
						MODE_JTAG: begin
							n.state = ST_JTAG;
						end
						default: begin
							n.state = ST_IDLE;
						end
					endcase
				end
			end
			ST_WAKE, ST_READ: begin
				// Command bits change on the falling edge; the flash takes them on the rise.
				if (tick) begin
					n.sck = !st.sck;
					if (st.sck) begin
						n.sh = st.sh << 1;
						n.cnt = st.cnt - 6'd1;
						if (st.cnt == 6'd1 && st.state == ST_WAKE) begin
							n.cs_n = 1'b1;
							n.state = ST_GAP;
							n.timer = 16'd0;
						end else if (st.cnt == 6'd1) begin
							n.state = ST_STREAM;
						end
					end
				end
			end
			ST_GAP: begin
				// Chip select stays high for the whole wake-up wait.
				n.timer = st.timer + 16'd1;
				if (st.timer == GAPC - 16'd1) begin
					n.state = ST_READ;
					n.cs_n = 1'b0;
					n.sh = {`CFL_CMD_FREAD, `CFL_START_ADDR};
					n.cnt = 6'(`CFL_CMD_BITS + 24 + `CFL_DUMMY_BITS);
					n.div = 3'd0;
				end
			end
			ST_STREAM: begin
				// A final write in this cycle has parked the clock low; a toggle must not undo it.
				if (tick && n.state == ST_STREAM) begin
					n.sck = !st.sck;
				end
				if (samp) begin
					n.sh = act_take(st.aw, st.sh, st.io2);
					n.bits = st.bits + act_w(st.aw);
				end
			end
			ST_PASSIVE: begin
				// The FIFO is only popped into an empty output buffer.
				if (f_rvalid && !st.pend) begin
					n.word = f_rdata;
					n.pend = 1'b1;
				end
			end
			ST_JTAG: begin
				// JTAG cannot stall; a bit arriving with both buffers full is dropped.
				if (st.s2 && st.t2 && !st.t3 && st.bits != WB) begin
					n.sh = {st.sh[30:0], st.d2};
					n.bits = st.bits + 6'd1;
				end
			end
			default: begin
				n.state = ST_DONE;
			end
		endcase
		// Pulling the reset pin low abandons any load and waits for the next rise.
		if (!st.rs2) begin
			n.state = ST_IDLE;
			n.cs_n = 1'b1;
			n.sck = 1'b0;
			n.bits = 6'd0;
			n.pend = 1'b0;
		end
	end

	assign f_rready = st.state == ST_PASSIVE && !st.pend;

	// System clock registers.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.cs_n <= 1'b1;
		end else begin
			st <= n;
		end
	end

	// User logic is released only once the last word is written.
	assign user_mode = st.state == ST_DONE;
	assign cfg_busy = st.state != ST_IDLE && st.state != ST_DONE;
	assign multi_image_ok = st.mimg;
	assign spi_sck = st.sck;
	assign spi_cs_n = st.cs_n;
	assign spi_io_o = {3'b000, st.sh[31]};
	assign spi_io_oe_n = {3'b111, !(st.state == ST_WAKE || st.state == ST_READ)};
	assign config_memory_we = st.pend;
	assign config_memory_addr = st.addr;
	assign config_memory_wdata = st.word;

	// Cycles spent in the wake-up wait, for checking only.
	logic [15:0] hgap;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hgap <= 16'd0;
		end else begin
			hgap <= (st.state == ST_GAP) ? hgap + 16'd1 : 16'd0;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	AST_DONE_ON_LAST: assert property ($rose(user_mode) |->
		$past(st.pend && config_memory_ready && st.addr == BITSTREAM_WORDS - 20'd1))
		else $error("user mode entered without final write");
	AST_START_EDGE: assert property (st.state == ST_IDLE && start && st.m2 == MODE_ACTIVE
		|=> st.state == ST_WAKE && !spi_cs_n)
		else $error("reset rise did not start active load");
	AST_SCK_HIGH: assert property ($rose(spi_sck) && st.state != ST_STREAM
		|-> spi_sck [*4] ##1 !spi_sck)
		else $error("flash clock high phase wrong");
	AST_WAKE_FIRST: assert property ($rose(st.state == ST_READ) |->
		$past(st.state) == ST_GAP)
		else $error("read entered without wake command");
	AST_GAP_LEN: assert property ($rose(st.state == ST_READ) |-> $past(hgap) == GAPI - 1)
		else $error("wake wait length wrong");
	AST_ADDR_ZERO: assert property (st.state == ST_READ && st.cnt <= 6'd32
		|-> !spi_io_o[0])
		else $error("nonzero read address bit");
	AST_MIMG_WIDTH: assert property (multi_image_ok |-> st.aw != AW_X1)
		else $error("multi-image at x1");
	AST_SCK_RUNS: assert property (st.state == ST_STREAM && st.bits != WB && !spi_sck
		|-> ##[1:5] (spi_sck || st.bits == WB || st.state != ST_STREAM))
		else $error("flash clock stalled");
	AST_MODE_MATCH: assert property ($rose(st.state == ST_PASSIVE) |->
		st.mode == MODE_PASSIVE)
		else $error("passive entered in wrong mode");

	COV_ACTIVE: cover property ($rose(user_mode) && st.mode == MODE_ACTIVE);
	COV_PASSIVE: cover property ($rose(user_mode) && st.mode == MODE_PASSIVE);
	COV_JTAG: cover property ($rose(user_mode) && st.mode == MODE_JTAG);
endmodule

// [verif/cfl_flash_model.sv]
// Behavioural serial flash that answers the loader's wake and fast read frames.
`timescale 1ns/1ps
module cfl_flash_model (
	// Flash pins as the memory sees them.
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] mosi,
	input wire logic [1:0] width_sel,
	output logic [3:0] miso,
	// Frame contents captured for the bench.
	output logic [7:0] wake_cmd,
	output int wake_bits,
	output logic [31:0] read_hdr,
	output int read_bits
);
	int nb; // Clock rises seen in the current frame.
	int w; // Data lines in use.
	int p; // Bit position in the stream, counted from address zero.
	logic [31:0] rx; // First 32 command bits of the frame.
	logic [31:0] wd; // Stored word being sent.
	initial begin
		nb = 0;
		rx = 32'h0;
		miso = 4'h0;
		wake_cmd = 8'h0;
		read_hdr = 32'h0;
	end
	// A new frame restarts the bit count.
	always @(negedge cs_n) begin
		nb = 0;
	end
	// Command bits are taken on the rising clock, most significant first.
	always @(posedge sck) begin
		if (!cs_n) begin
			if (nb < 32) rx = {rx[30:0], mosi[0]};
			nb = nb + 1;
		end
	end
	// On deselect the frame is filed; released lines stop showing the last value.
	always @(posedge cs_n) begin
		if (nb == 8) begin
			wake_cmd = rx[7:0];
			wake_bits = nb;
		end else begin
			read_hdr = rx;
			read_bits = nb;
		end
		miso = ~miso;
	end
	// Data leaves on the falling clock after 40 command, address and dummy clocks.
	always @(negedge sck) begin
		if (!cs_n && nb >= 40) begin
			w = (width_sel == 2'h2) ? 4 : (width_sel == 2'h1) ? 2 : 1;
			p = (nb - 40) * w;
			wd = 32'h1e2d3c4b ^ (32'(p / 32) * 32'h01030507);
			miso = ~miso;
			for (int i = 0; i < w; i++) begin
				miso[(w == 1) ? 1 : w - 1 - i] = wd[31 - p % 32 - i];
			end
		end
	end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the configuration loader: active, passive and JTAG loads.
`timescale 1ns/1ps
`include "cfl_defines.svh"
module tb_top;
	import cfl_pkg::*;
	localparam int NWORDS = 4; // A short bitstream keeps each load brief.
	logic mclk, rst_n, config_reset_n, multi_image_req, pas_clk, pas_run;
	cfl_mode_e cfg_mode;
	cfl_awidth_e act_width;
	logic [2:0] pas_width;
	logic user_mode, cfg_busy, multi_image_ok, spi_sck, spi_cs_n;
	logic [3:0] spi_io_o, spi_io_oe_n, spi_io_i;
	logic pas_cs_n, pas_ready, jtag_tck, jtag_tdi, jtag_shift, mem_we, mem_ready;
	logic [31:0] pas_data, mem_wdata, read_hdr;
	logic [19:0] mem_addr;
	logic [7:0] wake_cmd;
	int wake_bits, read_bits, num_errors, total_checks, widx, cyc;
	cfl_loader #(.BITSTREAM_WORDS(20'd4), .FIFO_DEPTH(4)) dut_u (
		.mclk(mclk), .rst_n(rst_n), .config_reset_n(config_reset_n), .cfg_mode(cfg_mode),
		.act_width(act_width), .pas_width(pas_width), .multi_image_req(multi_image_req),
		.user_mode(user_mode), .cfg_busy(cfg_busy), .multi_image_ok(multi_image_ok),
		.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_io_o(spi_io_o),
		.spi_io_oe_n(spi_io_oe_n), .spi_io_i(spi_io_i), .pas_clk(pas_clk),
		.pas_cs_n(pas_cs_n), .pas_data(pas_data), .pas_ready(pas_ready),
		.jtag_tck(jtag_tck), .jtag_tdi(jtag_tdi), .jtag_shift(jtag_shift),
		.config_memory_we(mem_we), .config_memory_addr(mem_addr),
		.config_memory_wdata(mem_wdata), .config_memory_ready(mem_ready)
	);
	cfl_flash_model flash_u (
		.sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_io_o), .width_sel(act_width),
		.miso(spi_io_i), .wake_cmd(wake_cmd), .wake_bits(wake_bits),
		.read_hdr(read_hdr), .read_bits(read_bits)
	);
	// Word k of the stored bitstream; the flash model holds the same pattern.
	function automatic logic [31:0] wv(input int k);
		return 32'h1e2d3c4b ^ (32'(k) * 32'h01030507);
	endfunction
	// One comparison; four-state so that an unknown never matches.
	task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// System clock at 40 MHz.
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// Link clock of 64 ns, offset in phase, standing still outside passive frames.
	initial begin
		pas_clk = 1'b0;
		#7;
		forever begin
			#32;
			if (pas_run) pas_clk = ~pas_clk;
		end
	end
	// A 64-cycle stall every 512 cycles fills the word buffers and the FIFO.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		mem_ready <= (cyc[8:6] != 3'b111);
	end
	// Every accepted memory write must be the next word at the next address.
	always @(posedge mclk) begin
		if (mem_we === 1'b1 && mem_ready === 1'b1) begin
			chk("memory address", 40'(widx), 40'(mem_addr));
			chk("memory word", 40'(wv(widx)), 40'(mem_wdata));
			widx++;
		end
	end
	// Holds the configuration reset low, then releases it to start a load.
	task automatic start_load(input cfl_mode_e m, input cfl_awidth_e aw, input logic [2:0] pw);
		@(posedge mclk);
		cfg_mode <= m;
		act_width <= aw;
		pas_width <= pw;
		// The multi-image request is withdrawn for x4 so that both of its levels are seen.
		multi_image_req <= (aw != AW_X4);
		config_reset_n <= 1'b0;
		repeat (50) @(posedge mclk);
		chk("user mode while held", 1'b0, user_mode);
		widx = 0;
		config_reset_n <= 1'b1;
	endtask
	// Waits, bounded, for user mode and checks the whole bitstream arrived.
	task automatic wait_done();
		int n;
		n = 0;
		while (user_mode !== 1'b1 && n < 40000) begin
			@(negedge mclk);
			n++;
		end
		repeat (4) @(negedge mclk);
		chk("user mode", 1'b1, user_mode);
		chk("words written", NWORDS, widx);
		chk("busy after load", 1'b0, cfg_busy);
		chk("flash lines released", 4'hf, spi_io_oe_n);
	endtask
	// Counts cycles, bounded, until the flash select reaches a level.
	task automatic wait_cs(input logic v, output int n);
		n = 0;
		while (spi_cs_n !== v && n < 40000) begin
			@(negedge mclk);
			n++;
		end
	endtask
	// Active load at one flash width: wake, gap, fast read, data, multi-image flag.
	task automatic run_active(input cfl_awidth_e aw);
		int n;
		int wb;
		wb = (aw == AW_X4) ? 4 : (aw == AW_X2) ? 2 : 1;
		start_load(MODE_ACTIVE, aw, 3'd0);
		wait_cs(1'b0, n);
		chk("load starts on release", 1'b1, n < 10);
		chk("flash line driven in wake", 4'he, spi_io_oe_n);
		chk("busy while loading", 1'b1, cfg_busy);
		wait_cs(1'b1, n);
		wait_cs(1'b0, n);
		// The wait must reach the full gap, and a hung select must not pass as a long one.
		chk("wake gap", 1'b1, n >= `CFL_WAKE_GAP_CYC && n < `CFL_WAKE_GAP_CYC + 4);
		chk("wake command", `CFL_CMD_WAKE, wake_cmd);
		chk("wake clocks", `CFL_CMD_BITS, wake_bits);
		wait_done();
		chk("read header", {`CFL_CMD_FREAD, `CFL_START_ADDR}, read_hdr);
		chk("read clocks", 1'b1, read_bits >= 40 + NWORDS * 32 / wb);
		chk("multi image", aw != AW_X1 && aw != AW_X4, multi_image_ok);
	endtask
	// Passive load at one bus width; upper unused lines carry junk.
	task automatic run_passive(input logic [2:0] pw);
		int bw;
		logic [31:0] m;
		logic [31:0] v;
		bw = 1 << pw;
		m = (bw == 32) ? 32'hffffffff : (32'h1 << bw) - 1;
		start_load(MODE_PASSIVE, AW_X1, pw);
		pas_run = 1'b1;
		repeat (4) @(posedge pas_clk);
		for (int i = 0; i < NWORDS * 32 / bw; i++) begin
			v = (wv(i * bw / 32) >> (32 - bw - (i * bw) % 32)) & m;
			pas_cs_n <= 1'b0;
			pas_data <= v | (~m & 32'h5a5a5a5a);
			#1;
			while (pas_ready !== 1'b1) begin
				@(posedge pas_clk);
				#1;
			end
			@(posedge pas_clk);
		end
		pas_cs_n <= 1'b1;
		pas_data <= ~v;
		repeat (2) @(posedge pas_clk);
		pas_run = 1'b0;
		wait_done();
		chk("flash select idle in passive", 1'b1, spi_cs_n);
	endtask
	// JTAG load, one bit per slow test clock, first bit to the top of the word.
	task automatic run_jtag();
		logic [31:0] t;
		start_load(MODE_JTAG, AW_X1, 3'd0);
		repeat (8) @(posedge mclk);
		for (int i = 0; i < NWORDS * 32; i++) begin
			t = wv(i / 32);
			jtag_tdi <= t[31 - i % 32];
			jtag_shift <= 1'b1;
			repeat (4) @(posedge mclk);
			jtag_tck <= 1'b1;
			repeat (4) @(posedge mclk);
			jtag_tck <= 1'b0;
		end
		jtag_shift <= 1'b0;
		wait_done();
	endtask
	// The reserved mode code must start no load at all.
	task automatic run_none();
		start_load(MODE_NONE, AW_X1, 3'd0);
		repeat (20) @(negedge mclk);
		chk("select in mode none", 1'b1, spi_cs_n);
		chk("busy in mode none", 1'b0, cfg_busy);
		chk("user mode in mode none", 1'b0, user_mode);
	endtask
	// Main sequence.
	initial begin
		{num_errors, total_checks, widx, cyc} = '0;
		{pas_run, jtag_tck, jtag_tdi, jtag_shift, pas_data} = '0;
		{rst_n, config_reset_n, multi_image_req, pas_cs_n, mem_ready} = 5'b01111;
		cfg_mode = MODE_NONE;
		act_width = AW_X1;
		pas_width = 3'h0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (100) @(negedge mclk);
		chk("select idle without release", 1'b1, spi_cs_n);
		chk("user mode before load", 1'b0, user_mode);
		run_active(AW_X1);
		run_active(AW_X2);
		run_active(AW_X4);
		run_passive(3'd5);
		run_passive(3'd3);
		run_jtag();
		run_none();
		summarize();
	end
	// Watchdog: the loads need about 200 us; a hang is cut at 2 ms.
	initial begin
		#2000000;
		num_errors++;
		summarize();
	end
endmodule
